// ---- hdl/pfr_pkg.sv ----
`default_nettype none
package pfr_pkg;

  // ----------------------------------------
  // Storage geometry
  // ----------------------------------------
  localparam int PFR_MAXB = 16;
  localparam int PFR_PAY_W = PFR_MAXB * 8;
  localparam int PFR_SRC_W = (12 + PFR_MAXB) * 8;
  localparam int PFR_REP_W = (24 + PFR_MAXB) * 8;
  localparam int PFR_WIN = 16;
  localparam int PFR_WIN_W = 4;
  localparam int PFR_NREP = 4;
  localparam int PFR_NREP_W = 2;

  // ----------------------------------------
  // Packet format constants
  // ----------------------------------------
  localparam logic [15:0] PFR_RTP_HDR_BYTES = 16'h000c;
  localparam logic [1:0] PFR_RTP_VERSION = 2'b10;
  // Sequence arithmetic wraps modulo this value by 16-bit width
  localparam int PFR_SEQ_MODULUS = 65536;
  localparam int PFR_MASK_MAX = 110;
  localparam logic [7:0] PFR_MASK_LEN0 = 8'h0f;
  localparam logic [7:0] PFR_MASK_LEN1 = 8'h2e;
  localparam logic [7:0] PFR_MASK_LEN2 = 8'h6e;
  localparam logic [5:0] PFR_FHDR_OFS = 6'h0c;
  localparam logic [5:0] PFR_FHDR_M0 = 6'h0c;
  localparam logic [5:0] PFR_FHDR_M1 = 6'h10;
  localparam logic [5:0] PFR_FHDR_M2 = 6'h18;

  // ----------------------------------------
  // Decoder states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PFR_IDLE = 3'b000,
    PFR_PICK = 3'b001,
    PFR_SCAN = 3'b010,
    PFR_FINISH = 3'b011,
    PFR_NEXT = 3'b100,
    PFR_ITER = 3'b101
  } pfr_state_t;

endpackage
`default_nettype wire

// ---- hdl/pfr_pad_bytes.sv ----
`default_nettype none
module pfr_pad_bytes #(
  parameter int NB = 16
) (
  input wire logic [NB*8-1:0] data,
  input wire logic [15:0] len,
  output logic [NB*8-1:0] padded
);

  // ----------------------------------------
  // Zero every octet at or past len, octet 0 in the top bits
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < NB; b++)
    begin : g_byte
      assign padded[NB*8-1-8*b -: 8] = (16'(b) < len) ? data[NB*8-1-8*b -: 8] : 8'h00;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- hdl/pfr_parity_recovery.sv ----
// Behaviour
// - Member sequence is base plus i times stride
// - Index runs zero through limit inclusive
// - Zero counts take configured values, type by PT
// - Source word: 64 header bits plus length-12
// - Repair word: first 80 FEC header bits
// - Recovered word XORs all sources and repair
// - Rebuilt header twelve bytes, version two
// - Copy P, X, CC, M, PT in order
// - Sequence from missing packet, skip 16 bits
// - Timestamp from next 32 recovered bits
// - Next 16 bits give recovered length
// - SSRC from the stream that lost it
// - Source payload taken from thirteenth octet
// - Short source payloads padded with trailing zeros
// - Repair payload follows variable-size FEC header
// - Payload XOR appended after rebuilt header
// - Both recovery counters cleared at start
// - Non-interleaved pass first, then interleaved
// - Repeat while running count grows, else stop
// - Mask bit i, MSB first, protects base+i
`default_nettype none
module pfr_parity_recovery (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SRC_VALID,
  output logic SRC_READY,
  input wire logic [pfr_pkg::PFR_SRC_W-1:0] SRC_PKT,
  input wire logic [15:0] SRC_LEN,
  input wire logic REP_VALID,
  output logic REP_READY,
  input wire logic [6:0] REP_PT,
  input wire logic [pfr_pkg::PFR_REP_W-1:0] REP_PKT,
  input wire logic [7:0] CFG_L,
  input wire logic [7:0] CFG_D,
  input wire logic [6:0] CFG_PT_INTERLEAVED,
  input wire logic [31:0] CFG_SSRC,
  input wire logic FLUSH,
  input wire logic START,
  output logic BUSY,
  output logic DONE,
  output logic [7:0] TOTAL_RECOVERED,
  output logic OUT_VALID,
  output logic [95:0] OUT_HDR,
  output logic [15:0] OUT_LEN,
  output logic [pfr_pkg::PFR_PAY_W-1:0] OUT_PAYLOAD
);

  localparam int SW = pfr_pkg::PFR_SRC_W;
  localparam int RW = pfr_pkg::PFR_REP_W;
  localparam int PW = pfr_pkg::PFR_PAY_W;
  localparam int MW = pfr_pkg::PFR_MASK_MAX;

  pfr_pkg::pfr_state_t state;

  logic s_valid [pfr_pkg::PFR_WIN];
  logic [15:0] s_seq [pfr_pkg::PFR_WIN];
  logic [79:0] s_hw [pfr_pkg::PFR_WIN];
  logic [PW-1:0] s_pay [pfr_pkg::PFR_WIN];

  logic r_valid [pfr_pkg::PFR_NREP];
  logic r_inter [pfr_pkg::PFR_NREP];
  logic r_mask_mode [pfr_pkg::PFR_NREP];
  logic [79:0] r_hw [pfr_pkg::PFR_NREP];
  logic [15:0] r_snb [pfr_pkg::PFR_NREP];
  logic [7:0] r_stride [pfr_pkg::PFR_NREP];
  logic [7:0] r_limit [pfr_pkg::PFR_NREP];
  logic [MW-1:0] r_mask [pfr_pkg::PFR_NREP];
  logic [PW-1:0] r_pay [pfr_pkg::PFR_NREP];
  logic [pfr_pkg::PFR_NREP_W-1:0] r_wr;

  logic [pfr_pkg::PFR_NREP_W-1:0] rslot;
  logic pass_cls;
  logic [7:0] scan_i;
  logic [1:0] miss_cnt;
  logic [15:0] miss_seq;
  logic [79:0] acc_h;
  logic [PW-1:0] acc_p;
  logic [7:0] run_cnt;
  logic [7:0] prev_cnt;

  // ----------------------------------------
  // Repair header parsing
  // ----------------------------------------
  logic p_rflag, p_fflag, p_oob, p_inter;
  logic [7:0] p_l, p_d, p_stride, p_limit;
  logic [5:0] p_hdr_bytes;
  logic [MW-1:0] p_mask;
  logic [RW-1:0] p_shift;

  always_comb
  begin
    p_rflag = REP_PKT[RW-1];
    p_fflag = REP_PKT[RW-2];
    p_l = p_fflag ? REP_PKT[RW-81 -: 8] : 8'h00;
    p_d = p_fflag ? REP_PKT[RW-89 -: 8] : 8'h00;
    p_oob = p_fflag && (p_l == 8'h00) && (p_d == 8'h00);
    if (p_oob)
    begin
      p_l = CFG_L;
      p_d = CFG_D;
      p_inter = (REP_PT == CFG_PT_INTERLEAVED);
    end
    else
    begin
      p_inter = p_fflag && (p_d != 8'h00);
    end
    p_stride = p_inter ? p_l : 8'h01;
    p_limit = p_inter ? p_d : p_l;
    // Mask kept left-aligned so index i always maps to bit MW-1-i
    if (REP_PKT[RW-81])
    begin
      p_hdr_bytes = pfr_pkg::PFR_FHDR_M0;
      p_mask = {REP_PKT[RW-82 -: 15], 95'd0};
      p_limit = p_fflag ? p_limit : pfr_pkg::PFR_MASK_LEN0 - 8'h01;
    end
    else if (REP_PKT[RW-97])
    begin
      p_hdr_bytes = pfr_pkg::PFR_FHDR_M1;
      p_mask = {REP_PKT[RW-82 -: 15], REP_PKT[RW-98 -: 31], 64'd0};
      p_limit = p_fflag ? p_limit : pfr_pkg::PFR_MASK_LEN1 - 8'h01;
    end
    else
    begin
      p_hdr_bytes = pfr_pkg::PFR_FHDR_M2;
      p_mask = {REP_PKT[RW-82 -: 15], REP_PKT[RW-98 -: 31], REP_PKT[RW-129 -: 64]};
      p_limit = p_fflag ? p_limit : pfr_pkg::PFR_MASK_LEN2 - 8'h01;
    end
    if (p_fflag)
    begin
      p_hdr_bytes = pfr_pkg::PFR_FHDR_OFS;
    end
    p_shift = REP_PKT << {p_hdr_bytes, 3'b000};
  end

  // ----------------------------------------
  // Scan lookup
  // ----------------------------------------
  logic [15:0] mem_seq;
  logic [pfr_pkg::PFR_WIN_W-1:0] mem_slot;
  logic mem_active, mem_present, scan_last;
  logic [PW-1:0] mem_pay;
  logic [PW-1:0] rec_pay;
  logic emit;

  always_comb
  begin
    if (r_mask_mode[rslot])
    begin
      mem_seq = r_snb[rslot] + {8'h00, scan_i};
      mem_active = r_mask[rslot][MW-1-scan_i];
    end
    else
    begin
      // 16-bit width gives the modulo 65536 wrap
      mem_seq = r_snb[rslot] + 16'({8'h00, scan_i} * {8'h00, r_stride[rslot]});
      mem_active = 1'b1;
    end
    mem_slot = mem_seq[pfr_pkg::PFR_WIN_W-1:0];
    mem_present = s_valid[mem_slot] && (s_seq[mem_slot] == mem_seq);
    scan_last = (scan_i == r_limit[rslot]);
  end

  pfr_pad_bytes #(.NB(pfr_pkg::PFR_MAXB)) u_pad_member (
    .data(s_pay[mem_slot]),
    .len(s_hw[mem_slot][15:0]),
    .padded(mem_pay)
  );

  pfr_pad_bytes #(.NB(pfr_pkg::PFR_MAXB)) u_pad_rec (
    .data(acc_p),
    .len(acc_h[15:0]),
    .padded(rec_pay)
  );

  assign emit = (state == pfr_pkg::PFR_FINISH) && (miss_cnt == 2'd1);
  assign SRC_READY = (state == pfr_pkg::PFR_IDLE);
  assign REP_READY = (state == pfr_pkg::PFR_IDLE);
  assign BUSY = (state != pfr_pkg::PFR_IDLE);
  assign TOTAL_RECOVERED = run_cnt;

  // ----------------------------------------
  // Source window, indexed by low sequence bits
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int k = 0; k < pfr_pkg::PFR_WIN; k++)
      begin
        s_valid[k] <= 1'b0;
        s_seq[k] <= 16'h0000;
        s_hw[k] <= 80'd0;
        s_pay[k] <= '0;
      end
    end
    else if (FLUSH && SRC_READY)
    begin
      for (int k = 0; k < pfr_pkg::PFR_WIN; k++)
      begin
        s_valid[k] <= 1'b0;
      end
    end
    else if (emit)
    begin
      // Rebuilt packets join the window so later passes can use them
      s_valid[miss_seq[pfr_pkg::PFR_WIN_W-1:0]] <= 1'b1;
      s_seq[miss_seq[pfr_pkg::PFR_WIN_W-1:0]] <= miss_seq;
      s_hw[miss_seq[pfr_pkg::PFR_WIN_W-1:0]] <= {pfr_pkg::PFR_RTP_VERSION, acc_h[77:64], miss_seq, acc_h[47:0]};
      s_pay[miss_seq[pfr_pkg::PFR_WIN_W-1:0]] <= rec_pay;
    end
    else if (SRC_VALID && SRC_READY)
    begin
      // Slot is the low sequence nibble, the same bits the scan lookup indexes by
      s_valid[SRC_PKT[SW-29 -: pfr_pkg::PFR_WIN_W]] <= 1'b1;
      s_seq[SRC_PKT[SW-29 -: pfr_pkg::PFR_WIN_W]] <= SRC_PKT[SW-17 -: 16];
      s_hw[SRC_PKT[SW-29 -: pfr_pkg::PFR_WIN_W]] <= {SRC_PKT[SW-1 -: 64], SRC_LEN - pfr_pkg::PFR_RTP_HDR_BYTES};
      s_pay[SRC_PKT[SW-29 -: pfr_pkg::PFR_WIN_W]] <= SRC_PKT[PW-1:0];
    end
  end

  // ----------------------------------------
  // Repair table, written round robin
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      r_wr <= '0;
      for (int k = 0; k < pfr_pkg::PFR_NREP; k++)
      begin
        r_valid[k] <= 1'b0;
        r_inter[k] <= 1'b0;
        r_mask_mode[k] <= 1'b0;
        r_hw[k] <= 80'd0;
        r_snb[k] <= 16'h0000;
        r_stride[k] <= 8'h00;
        r_limit[k] <= 8'h00;
        r_mask[k] <= '0;
        r_pay[k] <= '0;
      end
    end
    else if (FLUSH && REP_READY)
    begin
      r_wr <= '0;
      for (int k = 0; k < pfr_pkg::PFR_NREP; k++)
      begin
        r_valid[k] <= 1'b0;
      end
    end
    else if (REP_VALID && REP_READY && !p_rflag)
    begin
      r_wr <= r_wr + 1'b1;
      r_valid[r_wr] <= 1'b1;
      r_inter[r_wr] <= p_inter;
      r_mask_mode[r_wr] <= !p_fflag;
      r_hw[r_wr] <= REP_PKT[RW-1 -: 80];
      r_snb[r_wr] <= REP_PKT[RW-65 -: 16];
      r_stride[r_wr] <= p_stride;
      r_limit[r_wr] <= p_limit;
      r_mask[r_wr] <= p_mask;
      r_pay[r_wr] <= p_shift[RW-1 -: PW];
    end
  end

  // ----------------------------------------
  // Decoder sequence
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= pfr_pkg::PFR_IDLE;
      rslot <= '0;
      pass_cls <= 1'b0;
      scan_i <= 8'h00;
      miss_cnt <= 2'd0;
      miss_seq <= 16'h0000;
      acc_h <= 80'd0;
      acc_p <= '0;
      DONE <= 1'b0;
    end
    else
    begin
      DONE <= 1'b0;
      case (state)
        pfr_pkg::PFR_IDLE:
        begin
          if (START)
          begin
            state <= pfr_pkg::PFR_PICK;
            pass_cls <= 1'b0;
            rslot <= '0;
          end
        end
        pfr_pkg::PFR_PICK:
        begin
          if (r_valid[rslot] && (r_inter[rslot] == pass_cls))
          begin
            state <= pfr_pkg::PFR_SCAN;
            acc_h <= r_hw[rslot];
            acc_p <= r_pay[rslot];
            scan_i <= 8'h00;
            miss_cnt <= 2'd0;
          end
          else
          begin
            state <= pfr_pkg::PFR_NEXT;
          end
        end
        pfr_pkg::PFR_SCAN:
        begin
          if (mem_active && mem_present)
          begin
            acc_h <= acc_h ^ s_hw[mem_slot];
            acc_p <= acc_p ^ mem_pay;
          end
          else if (mem_active)
          begin
            // Saturates at two: any set past one loss is deferred
            miss_cnt <= (miss_cnt == 2'd0) ? 2'd1 : 2'd2;
            miss_seq <= mem_seq;
          end
          if (scan_last)
          begin
            state <= pfr_pkg::PFR_FINISH;
          end
          else
          begin
            scan_i <= scan_i + 8'h01;
          end
        end
        pfr_pkg::PFR_FINISH:
        begin
          state <= pfr_pkg::PFR_NEXT;
        end
        pfr_pkg::PFR_NEXT:
        begin
          if (rslot != pfr_pkg::PFR_NREP_W'(pfr_pkg::PFR_NREP - 1))
          begin
            rslot <= rslot + 1'b1;
            state <= pfr_pkg::PFR_PICK;
          end
          else if (!pass_cls)
          begin
            pass_cls <= 1'b1;
            rslot <= '0;
            state <= pfr_pkg::PFR_PICK;
          end
          else
          begin
            state <= pfr_pkg::PFR_ITER;
          end
        end
        pfr_pkg::PFR_ITER:
        begin
          if (run_cnt > prev_cnt)
          begin
            pass_cls <= 1'b0;
            rslot <= '0;
            state <= pfr_pkg::PFR_PICK;
          end
          else
          begin
            state <= pfr_pkg::PFR_IDLE;
            DONE <= 1'b1;
          end
        end
        default:
        begin
          state <= pfr_pkg::PFR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Recovery counters
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      run_cnt <= 8'h00;
      prev_cnt <= 8'h00;
    end
    else if (START && (state == pfr_pkg::PFR_IDLE))
    begin
      run_cnt <= 8'h00;
      prev_cnt <= 8'h00;
    end
    else if (emit)
    begin
      run_cnt <= run_cnt + 8'h01;
    end
    else if ((state == pfr_pkg::PFR_ITER) && (run_cnt > prev_cnt))
    begin
      prev_cnt <= run_cnt;
    end
  end

  // ----------------------------------------
  // Rebuilt packet output
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      OUT_VALID <= 1'b0;
      OUT_HDR <= 96'd0;
      OUT_LEN <= 16'h0000;
      OUT_PAYLOAD <= '0;
    end
    else
    begin
      OUT_VALID <= emit;
      if (emit)
      begin
        // Version forced, P X CC M PT copied, recovered sequence bits dropped
        OUT_HDR <= {pfr_pkg::PFR_RTP_VERSION, acc_h[77:64], miss_seq, acc_h[47:16], CFG_SSRC};
        OUT_LEN <= acc_h[15:0];
        OUT_PAYLOAD <= rec_pay;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_start_clears: assert property ((START && state == pfr_pkg::PFR_IDLE) |=> (run_cnt == 8'h00 && prev_cnt == 8'h00))
    else $error("counters not cleared at start");
  a_out_version: assert property (OUT_VALID |-> OUT_HDR[95:94] == 2'b10)
    else $error("rebuilt version not two");
  a_hdr_bits: assert property (OUT_VALID |-> OUT_HDR[93:80] == $past(acc_h[77:64]))
    else $error("flag fields misplaced");
  a_out_seq: assert property (OUT_VALID |-> OUT_HDR[79:64] == miss_seq)
    else $error("sequence not missing one");
  a_ts_field: assert property (OUT_VALID |-> OUT_HDR[63:32] == $past(acc_h[47:16]))
    else $error("timestamp wrong");
  a_len_field: assert property (OUT_VALID |-> OUT_LEN == $past(acc_h[15:0]))
    else $error("length wrong");
  a_out_ssrc: assert property (OUT_VALID |-> OUT_HDR[31:0] == $past(CFG_SSRC))
    else $error("ssrc wrong");
  a_single_miss: assert property (OUT_VALID |-> $past(miss_cnt) == 2'd1)
    else $error("emitted without single loss");
  a_count_step: assert property (OUT_VALID |-> run_cnt == $past(run_cnt) + 8'h01)
    else $error("running count not stepped");
  a_stop_rule: assert property ((state == pfr_pkg::PFR_ITER && run_cnt <= prev_cnt) |=> (DONE && !BUSY))
    else $error("did not stop");
  a_iter_again: assert property ((state == pfr_pkg::PFR_ITER && run_cnt > prev_cnt) |=> (prev_cnt == $past(run_cnt) && !DONE))
    else $error("did not iterate again");

  c_recover: cover property (OUT_VALID);
  c_second_iter: cover property (state == pfr_pkg::PFR_ITER && run_cnt > prev_cnt ##[1:1000] DONE);
  c_mask_scan: cover property (state == pfr_pkg::PFR_SCAN && r_mask_mode[rslot] && mem_active);
  c_nothing: cover property (DONE && run_cnt == 8'h00);

endmodule
`default_nettype wire

// ---- bench/pfr_rx_model.sv ----
`default_nettype none
// ----------------------------------------
// Receive path feeding source and repair packets
// ----------------------------------------
module pfr_rx_model (
  input wire logic clk,
  input wire logic src_ready,
  input wire logic rep_ready,
  output var logic src_valid,
  output var logic [pfr_pkg::PFR_SRC_W-1:0] src_pkt,
  output var logic [15:0] src_len,
  output var logic rep_valid,
  output var logic [6:0] rep_pt,
  output var logic [pfr_pkg::PFR_REP_W-1:0] rep_pkt
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    src_valid = 1'b0;
    src_pkt = '0;
    src_len = 16'h0000;
    rep_valid = 1'b0;
    rep_pt = 7'h00;
    rep_pkt = '0;
  end

  // Valid stays up after a transfer so back-to-back beats need no gap;
  // the other channel drops so its last packet is not taken twice.
  // Ready is read settled at the falling edge, never at the edge that moves it
  task automatic send_src(input logic [pfr_pkg::PFR_SRC_W-1:0] pkt, input logic [15:0] len);
    @(negedge clk);
    src_pkt = pkt;
    src_len = len;
    src_valid = 1'b1;
    rep_valid = 1'b0;
    while (src_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic send_rep(input logic [6:0] pt, input logic [pfr_pkg::PFR_REP_W-1:0] pkt);
    @(negedge clk);
    rep_pt = pt;
    rep_pkt = pkt;
    rep_valid = 1'b1;
    src_valid = 1'b0;
    while (rep_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  // Idle lines toggle every cycle so stale data can never look valid
  task automatic pause(input int n);
    repeat (n)
    begin
      @(negedge clk);
      src_valid = 1'b0;
      rep_valid = 1'b0;
      src_pkt = ~src_pkt;
      src_len = ~src_len;
      rep_pkt = ~rep_pkt;
      rep_pt = ~rep_pt;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/test_parity_fec_packet_recovery.sv ----
`default_nettype none
module test_parity_fec_packet_recovery;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SW = pfr_pkg::PFR_SRC_W;
  localparam int RW = pfr_pkg::PFR_REP_W;
  localparam int PW = pfr_pkg::PFR_PAY_W;

  logic clk, rst, src_valid, src_ready, rep_valid, rep_ready, flush, start, busy, done, out_valid;
  logic [SW-1:0] src_pkt;
  logic [RW-1:0] rep_pkt;
  logic [15:0] src_len, out_len;
  logic [6:0] rep_pt, cfg_pt_interleaved;
  logic [7:0] cfg_l, cfg_d, total_recovered;
  logic [31:0] cfg_ssrc;
  logic [95:0] out_hdr;
  logic [PW-1:0] out_payload;
  int error_cnt = 0;
  int check_count = 0;
  logic [SW-1:0] sp [int];
  logic [15:0] sl [int];
  int mem_q [$];
  logic [95:0] hq [$];
  logic [15:0] lq [$];
  logic [PW-1:0] pq [$];

  pfr_parity_recovery dut_u (.CLK(clk), .RST(rst), .SRC_VALID(src_valid), .SRC_READY(src_ready),
    .SRC_PKT(src_pkt), .SRC_LEN(src_len), .REP_VALID(rep_valid), .REP_READY(rep_ready), .REP_PT(rep_pt),
    .REP_PKT(rep_pkt), .CFG_L(cfg_l), .CFG_D(cfg_d), .CFG_PT_INTERLEAVED(cfg_pt_interleaved),
    .CFG_SSRC(cfg_ssrc), .FLUSH(flush), .START(start), .BUSY(busy), .DONE(done),
    .TOTAL_RECOVERED(total_recovered), .OUT_VALID(out_valid), .OUT_HDR(out_hdr), .OUT_LEN(out_len),
    .OUT_PAYLOAD(out_payload));

  pfr_rx_model rx_u (.clk(clk), .src_ready(src_ready), .rep_ready(rep_ready), .src_valid(src_valid),
    .src_pkt(src_pkt), .src_len(src_len), .rep_valid(rep_valid), .rep_pt(rep_pt), .rep_pkt(rep_pkt));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [PW-1:0] exp, input logic [PW-1:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [PW-1:0] keep(input int n);
    return ~({PW{1'b1}} >> (n * 8));
  endfunction

  task automatic do_flush();
    @(negedge clk);
    flush = 1'b1;
    @(negedge clk);
    flush = 1'b0;
    sp.delete();
    sl.delete();
  endtask

  // Field contents between the fixed version bits and the SSRC vary with the sequence so those header bits are exercised
  task automatic put_src(input int s, input int y);
    logic [SW-1:0] p;
    p = {2'b10, s[5:0], s[7:0] ^ 8'h5a, s[15:0], {2{s[15:0] ^ 16'h1234}}, 32'h0bad_cafe, {8{s[15:0] ^ 16'ha5c3}}};
    sp[s] = p;
    sl[s] = 16'(y + 12);
    rx_u.send_src(p, sl[s]);
  endtask

  task automatic put_rep(input logic [1:0] rf, input int b, input logic [47:0] tail, input logic [6:0] pt,
                         output logic [RW-1:0] r);
    r = {rf, 14'h1d2e, 16'h7e51, 32'h3c4d_5e6f, b[15:0], tail, {12{b[15:0] ^ 16'h96e1}}};
    rx_u.send_rep(pt, r);
  endtask

  task automatic decode(input int exp_n);
    int n;
    rx_u.pause(1);
    hq.delete();
    lq.delete();
    pq.delete();
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check_val("busy", 1'b1, busy);
    check_val("source ready", 1'b0, src_ready);
    n = 0;
    while (n < 3000 && done !== 1'b1)
    begin
      if (out_valid === 1'b1)
      begin
        hq.push_back(out_hdr);
        lq.push_back(out_len);
        pq.push_back(out_payload);
      end
      @(negedge clk);
      n++;
    end
    check_val("done", 1'b1, done);
    check_val("idle", 1'b0, busy);
    check_val("repair ready", 1'b1, rep_ready);
    check_val("total", exp_n, total_recovered);
    check_val("rebuilt count", exp_n, hq.size());
  endtask

  // Expected rebuild worked out from the members in mem_q; result joins the window
  task automatic expect_set(input int miss, input logic [RW-1:0] r, input int hb);
    logic [79:0] w;
    logic [PW-1:0] p;
    logic [RW-1:0] sh;
    logic [95:0] h;
    w = r[RW-1:RW-80];
    p = '0;
    foreach (mem_q[k])
      if (mem_q[k] != miss)
      begin
        w ^= {sp[mem_q[k]][SW-1:SW-64], sl[mem_q[k]] - 16'h000c};
        p ^= sp[mem_q[k]][PW-1:0] & keep(sl[mem_q[k]] - 12);
      end
    sh = r << (hb * 8);
    p = (p ^ sh[RW-1:RW-PW]) & keep(w[15:0]);
    h = {2'b10, w[77:64], miss[15:0], w[47:16], cfg_ssrc};
    if (hq.size() == 0)
    begin
      hq.push_back('x);
      lq.push_back('x);
      pq.push_back('x);
    end
    check_val("header", h, hq.pop_front());
    check_val("length", w[15:0], lq.pop_front());
    check_val("payload", p, pq.pop_front());
    sp[miss] = {h, p};
    sl[miss] = w[15:0] + 16'h000c;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_row();
    logic [RW-1:0] r;
    do_flush();
    put_src(8, 4);
    put_src(10, 2);
    put_rep(2'b01, 8, {8'h02, 8'h00, 32'h0000_0000}, 7'h60, r);
    decode(1);
    mem_q = '{8, 9, 10};
    expect_set(9, r, 12);
  endtask

  task automatic s_two_miss();
    logic [RW-1:0] r;
    do_flush();
    put_src(8, 4);
    put_rep(2'b01, 8, {8'h02, 8'h00, 32'h0000_0000}, 7'h60, r);
    decode(0);
  endtask

  // Counts zero in the header: stride and limit come from the configuration inputs
  task automatic s_oob();
    logic [RW-1:0] r;
    cfg_l = 8'h03;
    cfg_d = 8'h01;
    do_flush();
    put_src(4, 6);
    put_src(5, 9);
    put_src(6, 9);
    put_rep(2'b01, 4, 48'h0000_0000_0000, 7'h65, r);
    decode(1);
    mem_q = '{4, 7};
    expect_set(7, r, 12);
  endtask

  // 46-bit mask, offsets 0, 2 and 5; the header grows to 16 bytes
  task automatic s_mask();
    logic [RW-1:0] r;
    do_flush();
    put_src(2, 1);
    put_src(3, 9);
    put_src(5, 9);
    put_src(6, 9);
    put_src(7, 4);
    put_rep(2'b00, 2, {16'h5200, 16'h8000, 16'h0000}, 7'h60, r);
    decode(1);
    mem_q = '{2, 4, 7};
    expect_set(4, r, 16);
  endtask

  // Rows of three and one column: the first row only clears on the second iteration
  task automatic s_2d();
    logic [RW-1:0] r0, r1, r2;
    do_flush();
    put_src(2, 4);
    put_src(4, 4);
    put_src(5, 6);
    put_rep(2'b01, 0, {8'h02, 8'h00, 32'h0000_0000}, 7'h60, r0);
    put_rep(2'b01, 3, {8'h02, 8'h00, 32'h0000_0000}, 7'h60, r1);
    put_rep(2'b01, 0, {8'h03, 8'h01, 32'h0000_0000}, 7'h60, r2);
    decode(3);
    mem_q = '{3, 4, 5};
    expect_set(3, r1, 12);
    mem_q = '{0, 3};
    expect_set(0, r2, 12);
    mem_q = '{0, 1, 2};
    expect_set(1, r0, 12);
  endtask

  initial
  begin
    rst = 1'b1;
    flush = 1'b0;
    start = 1'b0;
    cfg_l = 8'h00;
    cfg_d = 8'h00;
    cfg_pt_interleaved = 7'h65;
    cfg_ssrc = 32'h5eed_0f0f;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    s_row();
    s_two_miss();
    s_oob();
    s_mask();
    s_2d();
    report_and_stop();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
